// file: verilog/cbag_top.sv
// Effective-address generator with circular and bit-reversed modes.
// Assumes the core presents requests synchronous to CORE_CLK and that the
// APB master follows the usual setup/access sequence.
module cbag_top
    import cbag_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // APB register port
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Address request from decode
    input wire logic REQ_VALID,
    input wire logic [2:0] REQ_UNIT,
    input wire logic [3:0] REQ_WREG,
    input wire logic [AW-1:0] REQ_PTR,
    input wire logic [4:0] REQ_MODE,
    input wire logic [2:0] REQ_WIDTH,
    input wire logic REQ_REVMOVE,
    // Address result to execute
    output logic EA_VALID,
    output logic [AW-1:0] EA_ADDR,
    output logic [AW-1:0] EA_PTR_NEXT,
    output logic EA_WRAPPED,
    output logic EA_REVERSED
);
    logic [AW-1:0] x_start_r;
    logic [AW-1:0] x_end_r;
    logic [AW-1:0] y_start_r;
    logic [AW-1:0] y_end_r;
    logic [15:0] mode_ctrl_r;
    logic [15:0] rev_ctrl_r;
    logic [AW-1:0] last_ea_r;
    logic last_wrap_r;
    logic last_rev_r;
    logic [2:0] unit_q_r;
    logic [2:0] width_q_r;
    logic revmove_q_r;

    logic [31:0] wmask;
    logic wr_en;
    logic apb_setup;
    logic addr_ok;
    logic [31:0] rd_nxt;

    cbag_unit_t unit;
    cbag_mode_t mode;
    cbag_width_t width;
    logic is_x;
    logic is_y;
    logic x_circ_on;
    logic y_circ_on;
    logic circ_hit;
    logic down;
    logic pre;
    logic [AW-1:0] mag;
    logic [AW-1:0] step;
    logic [AW-1:0] lin_next;
    logic [AW-1:0] c_start;
    logic [AW-1:0] c_end;
    logic [AW-1:0] circ_next;
    logic circ_wrap;
    logic [AW-1:0] rev_next;
    logic rev_act;
    logic [AW-1:0] ptr_nxt;
    logic wrap_nxt;
    logic [AW-1:0] ea_raw;
    logic [AW-1:0] ea_nxt;

    // APB decode
    genvar b;
    generate
        for (b = 0; b < 4; b++)
        begin : g_lane
            assign wmask[b*8 +: 8] = {8{PSTRB[b]}};
        end
    endgenerate

    assign apb_setup = PSEL && !PENABLE;
    assign wr_en = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;

    always_comb
    begin
        addr_ok = (PADDR[1:0] == 2'b00);
        rd_nxt = 32'h00000000;
        case (PADDR)
            OFF_X_START: rd_nxt = {8'h00, x_start_r};
            OFF_X_END: rd_nxt = {8'h00, x_end_r};
            OFF_Y_START: rd_nxt = {8'h00, y_start_r};
            OFF_Y_END: rd_nxt = {8'h00, y_end_r};
            OFF_MODE_CTRL: rd_nxt = {16'h0000, mode_ctrl_r};
            OFF_REV_CTRL: rd_nxt = {16'h0000, rev_ctrl_r};
            OFF_STATUS: rd_nxt = {6'h00, last_rev_r, last_wrap_r, last_ea_r};
            default: addr_ok = 1'b0;
        endcase
    end

    // One wait-free access cycle; ready is raised from the setup cycle
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end
        else
        begin
            PREADY <= apb_setup;
            PSLVERR <= apb_setup && !addr_ok;
            if (apb_setup)
                PRDATA <= (addr_ok && !PWRITE) ? rd_nxt : 32'h00000000;
        end
    end

    // Register file; writes honour byte strobes
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            x_start_r <= ADDR_RST;
            x_end_r <= ADDR_RST;
            y_start_r <= ADDR_RST;
            y_end_r <= ADDR_RST;
            mode_ctrl_r <= MODE_RST;
            rev_ctrl_r <= REV_RST;
        end
        else if (wr_en)
        begin
            case (PADDR)
                OFF_X_START: x_start_r <= AW'((x_start_r & ~wmask[AW-1:0])
                    | (PWDATA[AW-1:0] & wmask[AW-1:0]));
                OFF_X_END: x_end_r <= AW'((x_end_r & ~wmask[AW-1:0])
                    | (PWDATA[AW-1:0] & wmask[AW-1:0]));
                OFF_Y_START: y_start_r <= AW'((y_start_r & ~wmask[AW-1:0])
                    | (PWDATA[AW-1:0] & wmask[AW-1:0]));
                OFF_Y_END: y_end_r <= AW'((y_end_r & ~wmask[AW-1:0])
                    | (PWDATA[AW-1:0] & wmask[AW-1:0]));
                OFF_MODE_CTRL: mode_ctrl_r <= (mode_ctrl_r & ~wmask[15:0])
                    | (PWDATA[15:0] & wmask[15:0]);
                OFF_REV_CTRL: rev_ctrl_r <= (rev_ctrl_r & ~wmask[15:0])
                    | (PWDATA[15:0] & wmask[15:0]);
                default: ;
            endcase
        end
    end

    // Request decode
    assign unit = cbag_unit_t'(REQ_UNIT);
    assign mode = cbag_mode_t'(REQ_MODE);
    assign width = cbag_width_t'(REQ_WIDTH);
    assign is_x = (unit == CBAG_U_XRD) || (unit == CBAG_U_XWR);
    assign is_y = (unit == CBAG_U_YRD);

    assign x_circ_on = (mode_ctrl_r[XSEL_LSB +: 4] != SEL_NONE)
        && mode_ctrl_r[XEN_BIT]
        && (REQ_WREG == mode_ctrl_r[XSEL_LSB +: 4]);
    assign y_circ_on = (mode_ctrl_r[YSEL_LSB +: 4] != SEL_NONE)
        && mode_ctrl_r[YEN_BIT]
        && (REQ_WREG == mode_ctrl_r[YSEL_LSB +: 4]);
    assign circ_hit = (is_x && x_circ_on) || (is_y && y_circ_on);

    assign down = (mode == CBAG_M_POST_DEC) || (mode == CBAG_M_PRE_DEC);
    assign pre = (mode == CBAG_M_PRE_INC) || (mode == CBAG_M_PRE_DEC);

    always_comb
    begin
        case (width)
            CBAG_W_BYTE: mag = is_y ? 24'h000002 : 24'h000001;
            CBAG_W_WORD: mag = 24'h000002;
            CBAG_W_LONG: mag = 24'h000004;
            default: mag = 24'h000002;
        endcase
    end

    assign step = down ? AW'(24'h000000 - mag) : mag;
    assign lin_next = AW'(REQ_PTR + step);
    assign c_start = is_y ? y_start_r : x_start_r;
    assign c_end = is_y ? y_end_r : x_end_r;

    cbag_modulo u_modulo (
        .ptr(REQ_PTR),
        .step(step),
        .down(down),
        .start_a(c_start),
        .end_a(c_end),
        .next(circ_next),
        .wrapped(circ_wrap)
    );

    cbag_bitrev u_bitrev (
        .ptr(REQ_PTR),
        .pivot(rev_ctrl_r[PIVOT_W-1:0]),
        .long_w(width == CBAG_W_LONG),
        .next(rev_next)
    );

    // Reverse move may name one register as both pointers; no check needed
    assign rev_act = (unit == CBAG_U_XWR) && REQ_REVMOVE
        && rev_ctrl_r[REV_EN_BIT]
        && ((mode == CBAG_M_PRE_INC) || (mode == CBAG_M_POST_INC));

    always_comb
    begin
        ptr_nxt = lin_next;
        wrap_nxt = 1'b0;
        if (mode == CBAG_M_NONE)
            ptr_nxt = REQ_PTR;
        else if (rev_act)
            ptr_nxt = rev_next;
        else if (circ_hit)
        begin
            ptr_nxt = circ_next;
            wrap_nxt = circ_wrap;
        end
    end

    assign ea_raw = pre ? ptr_nxt : REQ_PTR;

    always_comb
    begin
        ea_nxt = ea_raw;
        // Alignment is forced, not trapped, for the reorder move
        if (REQ_REVMOVE && is_x)
        begin
            if (width == CBAG_W_LONG)
                ea_nxt[1:0] = 2'b00;
            else
                ea_nxt[0] = 1'b0;
        end
        if (is_y && circ_hit)
            ea_nxt[0] = 1'b0;
    end

    // Result stage: one cycle after the request
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            EA_VALID <= 1'b0;
            EA_ADDR <= ADDR_RST;
            EA_PTR_NEXT <= ADDR_RST;
            EA_WRAPPED <= 1'b0;
            EA_REVERSED <= 1'b0;
            unit_q_r <= CBAG_U_XRD;
            width_q_r <= CBAG_W_WORD;
            revmove_q_r <= 1'b0;
        end
        else
        begin
            EA_VALID <= REQ_VALID;
            if (REQ_VALID)
            begin
                EA_ADDR <= ea_nxt;
                EA_PTR_NEXT <= ptr_nxt;
                EA_WRAPPED <= wrap_nxt;
                EA_REVERSED <= rev_act;
                unit_q_r <= REQ_UNIT;
                width_q_r <= REQ_WIDTH;
                revmove_q_r <= REQ_REVMOVE;
            end
        end
    end

    // Status shows the most recent result
    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
        begin
            last_ea_r <= ADDR_RST;
            last_wrap_r <= 1'b0;
            last_rev_r <= 1'b0;
        end
        else if (REQ_VALID)
        begin
            last_ea_r <= ea_nxt;
            last_wrap_r <= wrap_nxt;
            last_rev_r <= rev_act;
        end
    end

    sequence s_setup;
        PSEL && !PENABLE;
    endsequence

    sequence s_access;
        PSEL && PENABLE && PREADY;
    endsequence

    a_apb_ready_one: assert property (@(posedge CORE_CLK) disable iff (RESET)
        s_setup |=> s_access or !PSEL)
        else $error("apb ready not raised after setup");

    a_start_reg_write: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        s_access ##0 (PWRITE && PADDR == OFF_X_START && PSTRB == 4'hF)
        |=> x_start_r == AW'($past(PWDATA)))
        else $error("x start register not written");

    a_ea_latency: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        REQ_VALID |=> EA_VALID && EA_ADDR == $past(ea_nxt))
        else $error("address not delivered one cycle after request");

    a_y_even_addr: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        REQ_VALID && is_y && circ_hit |=> EA_ADDR[0] == 1'b0)
        else $error("y circular address odd");

    a_rev_align_long: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        EA_VALID && revmove_q_r && unit_q_r != CBAG_U_YRD
        && width_q_r == CBAG_W_LONG |-> EA_ADDR[1:0] == 2'b00)
        else $error("reverse move long address misaligned");

    a_rev_write_only: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        EA_VALID && EA_REVERSED |-> unit_q_r == CBAG_U_XWR)
        else $error("bit reversal on a read unit");

    a_x_circ_gate: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        REQ_VALID && is_x && !rev_act
        && (mode_ctrl_r[XSEL_LSB +: 4] == SEL_NONE || !mode_ctrl_r[XEN_BIT])
        |=> !EA_WRAPPED)
        else $error("x wrap while circular disabled");

    a_y_circ_gate: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        REQ_VALID && is_y
        && (mode_ctrl_r[YSEL_LSB +: 4] == SEL_NONE || !mode_ctrl_r[YEN_BIT])
        |=> !EA_WRAPPED && EA_PTR_NEXT == $past(lin_next)
        || $past(REQ_MODE) == CBAG_M_NONE)
        else $error("y wrap while circular disabled");

    a_wrap_in_range: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        REQ_VALID && wrap_nxt |=> EA_PTR_NEXT >= $past(c_start)
        && EA_PTR_NEXT <= $past(c_end))
        else $error("wrapped pointer outside buffer");

    a_rev_precedence: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        REQ_VALID && rev_act && circ_hit
        |=> EA_PTR_NEXT == $past(rev_next) && !EA_WRAPPED)
        else $error("circular mode overrode bit reversal");
endmodule

// file: verilog/cbag_pkg.sv
// Constants, register map and encodings of the circular and bit-reversed
// address generator. Assumes one core clock and an APB register port.
package cbag_pkg;
    localparam int AW = 24;
    localparam int PIVOT_W = 15;
    localparam int REV_W = 17;
    localparam int EA_LATENCY = 1;

    localparam logic [11:0] OFF_X_START = 12'h000;
    localparam logic [11:0] OFF_X_END = 12'h004;
    localparam logic [11:0] OFF_Y_START = 12'h008;
    localparam logic [11:0] OFF_Y_END = 12'h00C;
    localparam logic [11:0] OFF_MODE_CTRL = 12'h010;
    localparam logic [11:0] OFF_REV_CTRL = 12'h014;
    localparam logic [11:0] OFF_STATUS = 12'h018;

    localparam int XSEL_LSB = 0;
    localparam int YSEL_LSB = 4;
    localparam int XEN_BIT = 15;
    localparam int YEN_BIT = 14;
    localparam int REV_EN_BIT = 15;
    localparam int ST_WRAP_BIT = 24;
    localparam int ST_REV_BIT = 25;
    localparam logic [3:0] SEL_NONE = 4'hF;

    localparam logic [23:0] ADDR_RST = 24'h000000;
    localparam logic [15:0] MODE_RST = 16'h00FF;
    localparam logic [15:0] REV_RST = 16'h0000;

    typedef enum logic [2:0] {
        CBAG_U_XRD = 3'b001,
        CBAG_U_XWR = 3'b010,
        CBAG_U_YRD = 3'b100
    } cbag_unit_t;

    typedef enum logic [4:0] {
        CBAG_M_NONE = 5'b00001,
        CBAG_M_POST_INC = 5'b00010,
        CBAG_M_POST_DEC = 5'b00100,
        CBAG_M_PRE_INC = 5'b01000,
        CBAG_M_PRE_DEC = 5'b10000
    } cbag_mode_t;

    typedef enum logic [2:0] {
        CBAG_W_BYTE = 3'b001,
        CBAG_W_WORD = 3'b010,
        CBAG_W_LONG = 3'b100
    } cbag_width_t;
endpackage

// file: verilog/cbag_modulo.sv
// Circular next-pointer calculation for one buffer.
// Assumes start <= end and a step no larger than the buffer length.
module cbag_modulo
    import cbag_pkg::*;
(
    // Operands
    input wire logic [AW-1:0] ptr,
    input wire logic [AW-1:0] step,
    input wire logic down,
    input wire logic [AW-1:0] start_a,
    input wire logic [AW-1:0] end_a,
    // Result
    output logic [AW-1:0] next,
    output logic wrapped
);
    logic [AW-1:0] len;
    logic [AW-1:0] sum;
    logic pow2;
    logic hi;
    logic lo;

    assign len = AW'(end_a - start_a + AW'(1));
    assign sum = AW'(ptr + step);
    assign pow2 = ((len & AW'(len - AW'(1))) == '0);
    assign hi = (sum > end_a);
    assign lo = (sum < start_a);

    always_comb
    begin
        next = sum;
        wrapped = 1'b0;
        // Only the edge facing the travel is checked unless length is 2^n
        if (hi && (!down || pow2))
        begin
            next = AW'(sum - len);
            wrapped = 1'b1;
        end
        else if (lo && (down || pow2))
        begin
            next = AW'(sum + len);
            wrapped = 1'b1;
        end
    end
endmodule

// file: verilog/cbag_bitrev.sv
// Reverse-carry pointer update for bit-reversed destination addressing.
// Assumes the buffer is aligned to its own size by software.
module cbag_bitrev
    import cbag_pkg::*;
(
    // Operands
    input wire logic [AW-1:0] ptr,
    input wire logic [PIVOT_W-1:0] pivot,
    input wire logic long_w,
    // Result
    output logic [AW-1:0] next
);
    logic [REV_W-1:0] mod;
    logic [REV_W-1:0] ptr_rev;
    logic [REV_W-1:0] mod_rev;
    logic [REV_W-1:0] sum_rev;
    logic [REV_W-1:0] sum;

    // Pivot counts elements; shift to bytes, by 2 for long and by 1 for word or byte
    assign mod = long_w ? {pivot, 2'b00} : {1'b0, pivot, 1'b0};

    genvar i;
    generate
        for (i = 0; i < REV_W; i++)
        begin : g_rev
            assign ptr_rev[i] = ptr[REV_W-1-i];
            assign mod_rev[i] = mod[REV_W-1-i];
            assign sum[i] = sum_rev[REV_W-1-i];
        end
    endgenerate

    assign sum_rev = REV_W'(ptr_rev + mod_rev);
    assign next = {ptr[AW-1:REV_W], sum};
endmodule

// file: tb/cbag_core_model.sv
// Model of the core decode stage that feeds address requests.
// Assumes the bench queues requests between clock edges, one per cycle out.
module cbag_core_model
    import cbag_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Address request
    output logic req_valid,
    output logic [2:0] req_unit,
    output logic [3:0] req_wreg,
    output logic [AW-1:0] req_ptr,
    output logic [4:0] req_mode,
    output logic [2:0] req_width,
    output logic req_revmove
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [39:0] pend_q[$];
    logic [39:0] cur;

    task automatic push(input logic [2:0] u, input logic [3:0] w,
        input logic [AW-1:0] p, input logic [4:0] m, input logic [2:0] wd,
        input logic rv);
        pend_q.push_back({u, w, p, m, wd, rv});
    endtask

    initial
    begin
        req_valid = 1'h0;
        {req_unit, req_wreg, req_ptr, req_mode, req_width, req_revmove} = '0;
    end

    // Idle fields toggle every cycle so stale values are never reused
    always @(posedge clk)
    begin
        if (rst || pend_q.size() == 0)
        begin
            req_valid <= 1'h0;
            {req_unit, req_wreg, req_ptr, req_mode, req_width, req_revmove}
                <= ~{req_unit, req_wreg, req_ptr, req_mode, req_width,
                req_revmove};
        end
        else
        begin
            cur = pend_q.pop_front();
            req_valid <= 1'h1;
            {req_unit, req_wreg, req_ptr, req_mode, req_width, req_revmove}
                <= cur;
        end
    end
endmodule

// file: tb/tb.sv
// Self-checking bench: registers over APB, requests through the core model.
// Assumes a one-cycle APB answer and a result one cycle after each request.
module tb
    import cbag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'h0;
    logic reset = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic req_valid, req_revmove;
    logic [2:0] req_unit, req_width;
    logic [3:0] req_wreg;
    logic [AW-1:0] req_ptr, ea_addr, ea_ptr_next;
    logic [4:0] req_mode;
    logic ea_valid, ea_wrapped, ea_reversed;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    always #4 core_clk = ~core_clk;

    cbag_core_model i_core (.clk(core_clk), .rst(reset),
        .req_valid(req_valid), .req_unit(req_unit), .req_wreg(req_wreg),
        .req_ptr(req_ptr), .req_mode(req_mode), .req_width(req_width),
        .req_revmove(req_revmove));

    cbag_top i_dut (.CORE_CLK(core_clk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .REQ_VALID(req_valid), .REQ_UNIT(req_unit), .REQ_WREG(req_wreg),
        .REQ_PTR(req_ptr), .REQ_MODE(req_mode), .REQ_WIDTH(req_width),
        .REQ_REVMOVE(req_revmove), .EA_VALID(ea_valid), .EA_ADDR(ea_addr),
        .EA_PTR_NEXT(ea_ptr_next), .EA_WRAPPED(ea_wrapped),
        .EA_REVERSED(ea_reversed));

    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'h1)
        begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] exp, input logic err);
        logic [31:0] rd;
        logic e;
        @(posedge core_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        // Wait until ready rises; only the bench timeout ends it if ready never comes
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'h1);
        rd = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        chk(e === err, "apb error flag");
        if (!wr)
            chk(rd === exp, "apb read data");
    endtask

    // f: revmove, expected wrap, expected reversed, compare next pointer
    task automatic expect_ea(input logic [3:0] f, input logic [23:0] ea,
        input logic [23:0] nx);
        chk(ea_valid === 1'h1, "result valid");
        chk(ea_addr === ea, "effective address");
        if (f[0])
            chk(ea_ptr_next === nx, "next pointer");
        chk(ea_wrapped === f[2], "wrap flag");
        chk(ea_reversed === f[1], "reverse flag");
    endtask

    task automatic xact(input logic [2:0] u, input logic [3:0] w,
        input logic [23:0] p, input logic [4:0] m, input logic [2:0] wd,
        input logic [3:0] f, input logic [23:0] ea, input logic [23:0] nx);
        @(negedge core_clk);
        i_core.push(u, w, p, m, wd, f[3]);
        @(posedge core_clk);
        @(posedge core_clk);
        #1;
        expect_ea(f, ea, nx);
    endtask

    // Byte offset of entry k of a 16-entry word buffer in reversed order
    function automatic logic [23:0] br(input int k);
        logic [3:0] v;
        v = k[3:0];
        return {19'h0, v[0], v[1], v[2], v[3], 1'h0};
    endfunction

    task automatic t_regs();
        apb(1'h0, OFF_MODE_CTRL, 32'h0, 32'h000000FF, 1'h0);
        apb(1'h0, OFF_Y_END, 32'h0, 32'h0, 1'h0);
        apb(1'h1, OFF_X_END, 32'hFFFFFFFF, 32'h0, 1'h0);
        apb(1'h0, OFF_X_END, 32'h0, 32'h00FFFFFF, 1'h0);
        apb(1'h1, OFF_REV_CTRL, 32'hFFFFFFFF, 32'h0, 1'h0);
        apb(1'h0, OFF_REV_CTRL, 32'h0, 32'h0000FFFF, 1'h0);
        apb(1'h0, 12'h01C, 32'h0, 32'h0, 1'h1);
        apb(1'h1, 12'h002, 32'h1, 32'h0, 1'h1);
        apb(1'h0, OFF_X_START, 32'h0, 32'h0, 1'h0);
        apb(1'h1, OFF_REV_CTRL, 32'h0, 32'h0, 1'h0);
        $display("test registers done");
    endtask

    task automatic t_timing();
        xact(CBAG_U_XRD, 4'h0, 24'h000400, CBAG_M_NONE, CBAG_W_LONG, 4'h1,
            24'h000400, 24'h000400);
        @(negedge core_clk);
        i_core.push(CBAG_U_XRD, 4'h1, 24'h000401, CBAG_M_POST_INC,
            CBAG_W_BYTE, 1'h0);
        i_core.push(CBAG_U_XRD, 4'h1, 24'h000408, CBAG_M_PRE_DEC,
            CBAG_W_LONG, 1'h0);
        repeat (2) @(posedge core_clk);
        #1;
        expect_ea(4'h1, 24'h000401, 24'h000402);
        @(posedge core_clk);
        #1;
        expect_ea(4'h1, 24'h000404, 24'h000404);
        @(posedge core_clk);
        #1;
        chk(ea_valid === 1'h0, "valid held too long");
        $display("test timing done");
    endtask

    task automatic t_xcirc();
        // 16-byte buffer, pointer register 3 away from 14 and 15
        apb(1'h1, OFF_X_START, 32'h1000, 32'h0, 1'h0);
        apb(1'h1, OFF_X_END, 32'h100F, 32'h0, 1'h0);
        apb(1'h1, OFF_MODE_CTRL, 32'h80F3, 32'h0, 1'h0);
        xact(CBAG_U_XRD, 4'h3, 24'h00100E, CBAG_M_POST_INC, CBAG_W_WORD,
            4'h5, 24'h00100E, 24'h001000);
        xact(CBAG_U_XWR, 4'h3, 24'h00100E, CBAG_M_PRE_INC, CBAG_W_WORD,
            4'h5, 24'h001000, 24'h001000);
        xact(CBAG_U_XRD, 4'h3, 24'h001000, CBAG_M_PRE_DEC, CBAG_W_WORD,
            4'h5, 24'h00100E, 24'h00100E);
        xact(CBAG_U_XRD, 4'h3, 24'h001012, CBAG_M_POST_DEC, CBAG_W_WORD,
            4'h5, 24'h001012, 24'h001000);
        // Length 12 is not a power of two: the upper edge is ignored going down
        apb(1'h1, OFF_X_END, 32'h100B, 32'h0, 1'h0);
        xact(CBAG_U_XRD, 4'h3, 24'h00100E, CBAG_M_POST_DEC, CBAG_W_WORD,
            4'h1, 24'h00100E, 24'h00100C);
        xact(CBAG_U_XRD, 4'h4, 24'h00100E, CBAG_M_POST_INC, CBAG_W_WORD,
            4'h1, 24'h00100E, 24'h001010);
        xact(CBAG_U_YRD, 4'h3, 24'h00100E, CBAG_M_POST_INC, CBAG_W_WORD,
            4'h1, 24'h00100E, 24'h001010);
        apb(1'h1, OFF_MODE_CTRL, 32'h00F3, 32'h0, 1'h0);
        xact(CBAG_U_XRD, 4'h3, 24'h00100E, CBAG_M_POST_INC, CBAG_W_WORD,
            4'h1, 24'h00100E, 24'h001010);
        apb(1'h1, OFF_MODE_CTRL, 32'h80FF, 32'h0, 1'h0);
        xact(CBAG_U_XRD, 4'hF, 24'h00100E, CBAG_M_POST_INC, CBAG_W_WORD,
            4'h1, 24'h00100E, 24'h001010);
        $display("test x circular done");
    endtask

    task automatic t_ycirc();
        apb(1'h1, OFF_Y_START, 32'h2000, 32'h0, 1'h0);
        apb(1'h1, OFF_Y_END, 32'h201F, 32'h0, 1'h0);
        apb(1'h1, OFF_MODE_CTRL, 32'h405F, 32'h0, 1'h0);
        xact(CBAG_U_YRD, 4'h5, 24'h00201E, CBAG_M_POST_INC, CBAG_W_BYTE,
            4'h5, 24'h00201E, 24'h002000);
        xact(CBAG_U_YRD, 4'h5, 24'h002011, CBAG_M_POST_INC, CBAG_W_WORD,
            4'h1, 24'h002010, 24'h002013);
        apb(1'h1, OFF_MODE_CTRL, 32'h005F, 32'h0, 1'h0);
        xact(CBAG_U_YRD, 4'h5, 24'h00201E, CBAG_M_POST_INC, CBAG_W_WORD,
            4'h1, 24'h00201E, 24'h002020);
        $display("test y circular done");
    endtask

    task automatic t_bitrev();
        // Buffer at 0x3000 aligned to its 32 bytes, pivot half of 16 words
        apb(1'h1, OFF_MODE_CTRL, 32'h00FF, 32'h0, 1'h0);
        apb(1'h1, OFF_REV_CTRL, 32'h8008, 32'h0, 1'h0);
        for (int k = 0; k < 4; k++)
            xact(CBAG_U_XWR, 4'h8, 24'h003000 + br(k), CBAG_M_POST_INC,
                CBAG_W_WORD, 4'hB, 24'h003000 + br(k),
                24'h003000 + br(k + 1));
        xact(CBAG_U_XWR, 4'h8, 24'h003000, CBAG_M_PRE_INC, CBAG_W_WORD,
            4'hB, 24'h003010, 24'h003010);
        xact(CBAG_U_XRD, 4'h8, 24'h003000, CBAG_M_POST_INC, CBAG_W_WORD,
            4'h9, 24'h003000, 24'h003002);
        xact(CBAG_U_XWR, 4'h8, 24'h003000, CBAG_M_POST_DEC, CBAG_W_WORD,
            4'h9, 24'h003000, 24'h002FFE);
        xact(CBAG_U_XWR, 4'h8, 24'h003000, CBAG_M_POST_INC, CBAG_W_WORD,
            4'h1, 24'h003000, 24'h003002);
        apb(1'h1, OFF_REV_CTRL, 32'h8004, 32'h0, 1'h0);
        xact(CBAG_U_XWR, 4'h8, 24'h003000, CBAG_M_POST_INC, CBAG_W_LONG,
            4'hB, 24'h003000, 24'h003010);
        xact(CBAG_U_XWR, 4'h8, 24'h003002, CBAG_M_POST_INC, CBAG_W_LONG,
            4'hB, 24'h003000, 24'h003012);
        apb(1'h1, OFF_REV_CTRL, 32'h0008, 32'h0, 1'h0);
        xact(CBAG_U_XWR, 4'h8, 24'h003000, CBAG_M_POST_INC, CBAG_W_WORD,
            4'h9, 24'h003000, 24'h003002);
        $display("test bit reverse done");
    endtask

    task automatic t_both();
        apb(1'h1, OFF_X_START, 32'h3000, 32'h0, 1'h0);
        apb(1'h1, OFF_X_END, 32'h301F, 32'h0, 1'h0);
        apb(1'h1, OFF_MODE_CTRL, 32'h80F9, 32'h0, 1'h0);
        apb(1'h1, OFF_REV_CTRL, 32'h8008, 32'h0, 1'h0);
        xact(CBAG_U_XWR, 4'h9, 24'h003010, CBAG_M_POST_INC, CBAG_W_WORD,
            4'hB, 24'h003010, 24'h003008);
        xact(CBAG_U_XRD, 4'h9, 24'h00301E, CBAG_M_POST_INC, CBAG_W_WORD,
            4'h5, 24'h00301E, 24'h003000);
        apb(1'h0, OFF_STATUS, 32'h0, 32'h0100301E, 1'h0);
        $display("test combined modes done");
    endtask

    initial
    begin
        repeat (4) @(posedge core_clk);
        reset <= 1'h0;
        t_regs();
        t_timing();
        t_xcirc();
        t_ycirc();
        t_bitrev();
        t_both();
        report_and_stop();
    end

    // Whole run needs about 150 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            $display("mismatch at %0t: run timed out", $time);
            report_and_stop();
        end
    end
endmodule
